// ### hdl/cst_clock_sources.sv
// Purpose: clock source control, thirteen glitch-free dividers, pll lock
//          tracking and the slow and fast periodic counters
// Assumes: every oscillator arrives as a pin level, sampled on core_clk_i
// Notes:   dividers count rising edges of their source seen at 25 MHz
//
// What this block does
// - seven clock sources feed all dividers
// - main oscillator six ranges, own trims
// - main oscillator trims itself to usb frames
// - doubler output is twice its input
// - doubler input from three sources
// - pll reference from three sources
// - pll dividers give 4032 ratios
// - pll lock within 250 us, pollable
// - pll reference used by the bus divider until lock done
// - pll lock event routable to interrupt
// - low speed oscillator gives three clocks
// - third clock is 100 kHz over three
// - slow counter 13 bits on 1 kHz
// - slow counter stops in hibernate, debug halt
// - software write clears slow counter
// - slow counter periodic wakeups, optional interrupt
// - fast counter 5 bits, programmable terminal
// - fast counter wraps at terminal count
// - fast counter interrupt at terminal count
// - watch crystal gives one-second event
// - eight digital, four analog, one bus divider
// - eight extra routed clocks, one per digital divider
// - eight-input mux, divide by two up
// - cpu clock is bus clock from system
`timescale 1ns/10ps
`default_nettype none
`include "cst_consts.svh"

module cst_clock_sources #(
  parameter int PLL_LOCK_CYCLES = `CST_PLL_LOCK_US * `CST_CORE_MHZ
) (
  input  wire logic                                  core_clk_i,
  input  wire logic                                  arst_n_i,
  // oscillator and routed clock pins
  input  wire logic                                  internal_main_osc_i,
  input  wire logic                                  fast_crystal_osc_i,
  input  wire logic                                  routed_clk_i,
  input  wire logic                                  pll_clk_i,
  input  wire logic                                  doubler_clk_i,
  input  wire logic                                  fast_low_power_clock_i,
  input  wire logic                                  slow_tick_clock_i,
  input  wire logic                                  watch_crystal_osc_i,
  input  wire logic [`CST_NUM_DIG_DIV-1:0]           routed_div_clk_i,
  input  wire logic                                  usb_sof_i,
  // dividers
  input  wire logic [`CST_NUM_DIV-2:0][2:0]          div_sel_i,
  input  wire logic [`CST_NUM_DIV-1:0][`CST_DIV_W-1:0] div_val_i,
  input  wire cst_pkg::cst_sel_t                     sys_src_sel_i,
  output logic [`CST_NUM_DIV-1:0]                    div_clk_o,
  output logic                                       cpu_clk_o,
  // pll
  input  wire logic                                  pll_enable_i,
  input  wire logic [1:0]                            pll_ref_sel_i,
  input  wire logic [3:0]                            pll_in_div_i,
  input  wire logic [7:0]                            pll_fb_div_i,
  output logic                                       pll_ref_clk_o,
  output logic                                       pll_ratio_ok_o,
  output logic                                       pll_locked_o,
  output logic                                       pll_lock_event_o,
  // doubler
  input  wire logic [1:0]                            doubler_sel_i,
  output logic                                       doubler_ref_clk_o,
  // internal main oscillator
  input  wire cst_pkg::cst_sel_t                     imo_range_sel_i,
  input  wire logic [`CST_IMO_RANGES*`CST_TRIM_W-1:0] imo_factory_trim_i,
  input  wire logic                                  imo_usb_lock_i,
  output cst_pkg::cst_sel_t                          imo_range_o,
  output cst_pkg::cst_trim_t                         imo_trim_o,
  // low speed clocks and counters
  output logic                                       divided_third_clock_o,
  input  wire logic                                  hibernate_i,
  input  wire logic                                  debug_halt_i,
  input  wire logic                                  spc_clear_i,
  input  wire logic                                  spc_wake_en_i,
  input  wire logic                                  spc_irq_en_i,
  input  wire logic [3:0]                            spc_wake_sel_i,
  output logic [`CST_SPC_W-1:0]                      slow_periodic_counter_o,
  output logic                                       spc_wake_o,
  output logic                                       spc_irq_o,
  input  wire logic [`CST_FPC_W-1:0]                 fpc_terminal_i,
  input  wire logic                                  fpc_irq_en_i,
  output logic [`CST_FPC_W-1:0]                      fast_periodic_counter_o,
  output logic                                       fpc_irq_o,
  output logic                                       one_second_o
);
  import cst_pkg::*;

  cst_state_s             r;
  cst_state_s             n;
  logic [`CST_SYNC_W-1:0] raw;
  logic [`CST_SYNC_W-1:0] rise;
  cst_sel_t               sys_eff;

  assign raw = {usb_sof_i, routed_div_clk_i, slow_tick_clock_i, watch_crystal_osc_i,
                fast_low_power_clock_i, doubler_clk_i, pll_clk_i, routed_clk_i,
                fast_crystal_osc_i, internal_main_osc_i};
  // edges read stages two and three only
  assign rise = r.s2 & ~r.s3;

  // pll output only once locked, else its reference stands in
  always_comb begin
    if (sys_src_sel_i == `CST_SEL_PLL && !r.pll_locked) begin
      // reference code 3 means the main oscillator, never the pll itself
      sys_eff = (pll_ref_sel_i == 2'h3) ? 3'(`CST_SLOT_IMO) : {1'b0, pll_ref_sel_i};
    end else begin
      sys_eff = sys_src_sel_i;
    end
  end

  always_comb begin
    cst_div_t               lim;
    cst_sel_t               sel_in;
    logic                   tick;
    logic [14:0]            cfg;
    logic [`CST_SPC_W-1:0]  spc_nxt;
    logic [`CST_SPC_W-1:0]  mask;
    logic                   adv;
    logic [2:0]             dsel_src;
    lim      = `CST_DIV_MIN;
    sel_in   = '0;
    tick     = 1'b0;
    cfg      = '0;
    spc_nxt  = '0;
    mask     = '0;
    adv      = 1'b0;
    dsel_src = '0;
    n = r;
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.pll_lock_evt = 1'b0;
    n.spc_wake = 1'b0;
    n.spc_irq = 1'b0;
    n.fpc_irq = 1'b0;
    n.sec_evt = 1'b0;

    // dividers: 0..7 digital, 8..11 analog, 12 bus
    for (int i = 0; i < `CST_NUM_DIV; i++) begin
      sel_in = (i == `CST_NUM_DIV - 1) ? sys_eff : div_sel_i[i];
      dsel_src = r.dsel[i];
      if (dsel_src == `CST_SEL_ALT) begin
        tick = (i < `CST_NUM_DIG_DIV) ? rise[`CST_SLOT_ROUTED_DIV + i]
                                      : rise[`CST_SLOT_SLOW_TICK];
      end else begin
        tick = rise[dsel_src];
      end
      lim = (r.ddiv[i] < `CST_DIV_MIN) ? `CST_DIV_MIN : r.ddiv[i];
      if (tick) begin
        if (r.dcnt[i] >= lim - `CST_DIV_MIN + 16'h0001) begin
          n.dcnt[i] = '0;
          // new source and ratio only at a period boundary
          n.dsel[i] = sel_in;
          n.ddiv[i] = div_val_i[i];
        end else begin
          n.dcnt[i] = r.dcnt[i] + 16'h0001;
        end
      end
      n.dout[i] = r.dcnt[i] < (lim >> 1);
    end

    // pll configuration and lock tracking
    cfg = {pll_enable_i, pll_ref_sel_i, pll_in_div_i, pll_fb_div_i};
    n.pll_cfg = cfg;
    n.pll_cfg_ok = (pll_fb_div_i >= `CST_PLL_FB_MIN);
    n.pll_ref = (pll_ref_sel_i == 2'h3) ? r.s2[`CST_SLOT_IMO] : r.s2[pll_ref_sel_i];
    if (!pll_enable_i || cfg != r.pll_cfg || !n.pll_cfg_ok) begin
      n.pll_cnt = '0;
      n.pll_locked = 1'b0;
    end else if (!r.pll_locked) begin
      if (32'(r.pll_cnt) >= PLL_LOCK_CYCLES - 1) begin
        n.pll_locked = 1'b1;
        n.pll_lock_evt = 1'b1;
      end else begin
        n.pll_cnt = r.pll_cnt + 16'h0001;
      end
    end

    // doubler reference; the doubled clock itself returns on doubler_clk_i
    n.dbl_ref = (doubler_sel_i == 2'h3) ? r.s2[`CST_SLOT_IMO] : r.s2[doubler_sel_i];

    // main oscillator range and trim
    if (imo_range_sel_i < 3'(`CST_IMO_RANGES)) begin
      n.imo_sel = imo_range_sel_i;
    end
    if (rise[`CST_SLOT_IMO]) begin
      n.imo_cnt = r.imo_cnt + 16'h0001;
    end
    if (!imo_usb_lock_i) begin
      n.imo_off = '0;
    end else if (rise[`CST_SLOT_USB_SOF]) begin
      n.imo_cnt = '0;
      // nudge trim one step per frame toward the expected edge count
      if (r.imo_cnt > `CST_USB_EXPECT && r.imo_off != 8'h80) begin
        n.imo_off = r.imo_off - 8'h01;
      end else if (r.imo_cnt < `CST_USB_EXPECT && r.imo_off != 8'h7F) begin
        n.imo_off = r.imo_off + 8'h01;
      end
    end
    n.imo_trim = imo_factory_trim_i[r.imo_sel*`CST_TRIM_W +: `CST_TRIM_W] + r.imo_off;

    // one third of the fast low power clock
    if (rise[`CST_SLOT_FAST_LP]) begin
      n.third_cnt = (r.third_cnt == `CST_THIRD_LAST) ? 2'h0 : r.third_cnt + 2'h1;
    end
    n.third_clk = (r.third_cnt == 2'h0);

    // slow periodic counter
    adv = rise[`CST_SLOT_SLOW_TICK] && !hibernate_i && !debug_halt_i;
    spc_nxt = r.spc + 13'h0001;
    mask = 13'((14'h0002 << spc_wake_sel_i) - 14'h0001);
    if (spc_clear_i) begin
      n.spc = '0;
    end else if (adv) begin
      n.spc = spc_nxt;
      if (spc_wake_en_i && (spc_nxt & mask) == 13'h0000) begin
        n.spc_wake = 1'b1;
        n.spc_irq = spc_irq_en_i;
      end
    end

    // fast periodic counter
    if (rise[`CST_SLOT_FAST_LP]) begin
      if (r.fpc >= fpc_terminal_i) begin
        n.fpc = '0;
        n.fpc_irq = fpc_irq_en_i;
      end else begin
        n.fpc = r.fpc + 5'h01;
      end
    end

    // one-second event from the watch crystal
    if (rise[`CST_SLOT_WATCH]) begin
      if (r.sec_cnt == `CST_WATCH_LAST) begin
        n.sec_cnt = '0;
        n.sec_evt = 1'b1;
      end else begin
        n.sec_cnt = r.sec_cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
      r.ddiv <= {`CST_NUM_DIV{`CST_DIV_MIN}};
      r.imo_sel <= `CST_IMO_SEL_RESET;
    end else begin
      r <= n;
    end
  end

  assign div_clk_o = r.dout;
  assign cpu_clk_o = r.dout[`CST_NUM_DIV-1];
  assign pll_ref_clk_o = r.pll_ref;
  assign pll_ratio_ok_o = r.pll_cfg_ok;
  assign pll_locked_o = r.pll_locked;
  assign pll_lock_event_o = r.pll_lock_evt;
  assign doubler_ref_clk_o = r.dbl_ref;
  assign imo_range_o = r.imo_sel;
  assign imo_trim_o = r.imo_trim;
  assign divided_third_clock_o = r.third_clk;
  assign slow_periodic_counter_o = r.spc;
  assign spc_wake_o = r.spc_wake;
  assign spc_irq_o = r.spc_irq;
  assign fast_periodic_counter_o = r.fpc;
  assign fpc_irq_o = r.fpc_irq;
  assign one_second_o = r.sec_evt;

endmodule : cst_clock_sources
`default_nettype wire

// ### hdl/cst_consts.svh
// Purpose: constants of the clock source and periodic counter block
// Assumes: core clock of 25 MHz
// Notes:   counts derived from times live in the top module
`ifndef CST_CONSTS_SVH
`define CST_CONSTS_SVH

// core clock rate and pll lock bound
`define CST_CORE_MHZ        25
`define CST_PLL_LOCK_US     250

// divider count, digital divider count, divider width
`define CST_NUM_DIV         13
`define CST_NUM_DIG_DIV     8
`define CST_DIV_W           16
`define CST_DIV_MIN         16'h0002

// synchronised input slots
`define CST_SYNC_W          17
`define CST_SLOT_IMO        0
`define CST_SLOT_FAST_XTAL  1
`define CST_SLOT_ROUTED     2
`define CST_SLOT_PLL        3
`define CST_SLOT_DOUBLER    4
`define CST_SLOT_FAST_LP    5
`define CST_SLOT_WATCH      6
`define CST_SLOT_SLOW_TICK  7
`define CST_SLOT_ROUTED_DIV 8
`define CST_SLOT_USB_SOF    16

// source selection codes of the pll output and the alternate input
`define CST_SEL_PLL         3'h3
`define CST_SEL_ALT         3'h7

// pll divider limits: 16 input settings times 252 feedback settings
`define CST_PLL_FB_MIN      8'h04

// internal main oscillator ranges and trim
`define CST_IMO_RANGES      6
`define CST_IMO_SEL_RESET   3'h2
`define CST_TRIM_W          8
`define CST_USB_EXPECT      16'h5DC0

// counters
`define CST_SPC_W           13
`define CST_FPC_W           5
`define CST_THIRD_LAST      2'h2
`define CST_WATCH_LAST      15'h7FFF

`endif

// ### hdl/cst_pkg.sv
// Purpose: types of the clock source and periodic counter block
// Assumes: constants come from cst_consts.svh
// Notes:   whole block state is one packed struct
`include "cst_consts.svh"

package cst_pkg;

  typedef logic [`CST_DIV_W-1:0]  cst_div_t;
  typedef logic [2:0]             cst_sel_t;
  typedef logic [`CST_TRIM_W-1:0] cst_trim_t;

  typedef struct packed {
    logic [`CST_SYNC_W-1:0]              s1;
    logic [`CST_SYNC_W-1:0]              s2;
    logic [`CST_SYNC_W-1:0]              s3;
    logic [`CST_NUM_DIV-1:0][`CST_DIV_W-1:0] dcnt;
    logic [`CST_NUM_DIV-1:0][`CST_DIV_W-1:0] ddiv;
    logic [`CST_NUM_DIV-1:0][2:0]        dsel;
    logic [`CST_NUM_DIV-1:0]             dout;
    logic [15:0]                         pll_cnt;
    logic [14:0]                         pll_cfg;
    logic                                pll_locked;
    logic                                pll_lock_evt;
    logic                                pll_ref;
    logic                                pll_cfg_ok;
    logic                                dbl_ref;
    cst_sel_t                            imo_sel;
    cst_trim_t                           imo_off;
    cst_trim_t                           imo_trim;
    logic [15:0]                         imo_cnt;
    logic [1:0]                          third_cnt;
    logic                                third_clk;
    logic [`CST_SPC_W-1:0]               spc;
    logic                                spc_wake;
    logic                                spc_irq;
    logic [`CST_FPC_W-1:0]               fpc;
    logic                                fpc_irq;
    logic [14:0]                         sec_cnt;
    logic                                sec_evt;
  } cst_state_s;

endpackage : cst_pkg

// ### tb/cst_clock_sources_checker.sv
// Purpose: port-level checks on the clock source block
// Assumes: one core clock domain, asynchronous active-low reset
// Notes:   bound to every cst_clock_sources instance
`timescale 1ns/10ps
`default_nettype none
`include "cst_consts.svh"
module cst_clock_sources_checker #(
  parameter int PLL_LOCK_CYCLES = 6250
) (
  input wire logic                     core_clk_i,
  input wire logic                     arst_n_i,
  input wire logic                     pll_enable_i,
  input wire logic                     pll_ratio_ok_o,
  input wire logic                     pll_locked_o,
  input wire logic                     pll_lock_event_o,
  input wire logic [`CST_NUM_DIV-1:0]  div_clk_o,
  input wire logic                     cpu_clk_o,
  input wire cst_pkg::cst_sel_t        imo_range_o,
  input wire logic                     hibernate_i,
  input wire logic                     debug_halt_i,
  input wire logic                     spc_clear_i,
  input wire logic [`CST_SPC_W-1:0]    slow_periodic_counter_o,
  input wire logic                     spc_wake_o,
  input wire logic                     spc_irq_o,
  input wire logic [`CST_FPC_W-1:0]    fpc_terminal_i,
  input wire logic [`CST_FPC_W-1:0]    fast_periodic_counter_o,
  input wire logic                     fpc_irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_lock_needs_ratio: assert property (pll_locked_o |-> pll_ratio_ok_o)
    else $error("pll locked with an unusable ratio");
  a_lock_event_once: assert property (pll_lock_event_o |-> pll_locked_o ##1 !pll_lock_event_o)
    else $error("lock event not a single pulse at lock");
  a_lock_drop_off: assert property ($fell(pll_enable_i) |-> ##[1:3] !pll_locked_o)
    else $error("lock kept after pll disable");
  a_cpu_bus_same: assert property (cpu_clk_o == div_clk_o[12])
    else $error("cpu clock differs from bus clock");
  a_imo_range_legal: assert property (imo_range_o < 3'h6)
    else $error("main oscillator range out of set");
  a_spc_clear_zero: assert property (spc_clear_i |=> slow_periodic_counter_o == 13'h0)
    else $error("slow counter not cleared");
  a_spc_stop_hold: assert property ((hibernate_i || debug_halt_i) && !spc_clear_i
    |=> $stable(slow_periodic_counter_o))
    else $error("slow counter moved while stopped");
  a_spc_step_one: assert property ($changed(slow_periodic_counter_o) && !$past(spc_clear_i)
    |-> slow_periodic_counter_o == 13'($past(slow_periodic_counter_o) + 13'h1))
    else $error("slow counter step not one");
  a_spc_irq_wake: assert property (spc_irq_o |-> spc_wake_o)
    else $error("slow counter interrupt without wake");
  a_fpc_step_wrap: assert property ($changed(fast_periodic_counter_o)
    && fast_periodic_counter_o != 5'h0
    |-> $past(fast_periodic_counter_o) < $past(fpc_terminal_i))
    else $error("fast counter passed its terminal");
  a_fpc_irq_zero: assert property (fpc_irq_o |-> fast_periodic_counter_o == 5'h0)
    else $error("fast counter interrupt off wrap");

  c_lock: cover property (pll_lock_event_o);
  c_fpc_irq: cover property (fpc_irq_o);
  c_spc_wake: cover property (spc_wake_o && spc_irq_o);
endmodule : cst_clock_sources_checker

bind cst_clock_sources cst_clock_sources_checker #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_chk (
  .core_clk_i, .arst_n_i, .pll_enable_i, .pll_ratio_ok_o, .pll_locked_o, .pll_lock_event_o,
  .div_clk_o, .cpu_clk_o, .imo_range_o, .hibernate_i, .debug_halt_i, .spc_clear_i,
  .slow_periodic_counter_o, .spc_wake_o, .spc_irq_o, .fpc_terminal_i,
  .fast_periodic_counter_o, .fpc_irq_o
);
`default_nettype wire

// ### tb/cst_clock_sources_bench.sv
// Purpose: self-checking bench of the clock source block
// Assumes: 25 MHz core clock, source pins toggled slowly by the bench
// Notes:   short pll lock count of 20 cycles
`timescale 1ns/10ps
`default_nettype none
`include "cst_consts.svh"
`define CHK(nm, ex, got) \
  n_checks++; \
  if ((got) !== (ex)) begin \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
    n_errors++; \
  end
module cst_clock_sources_bench;
  import cst_pkg::*;
  localparam int LOCK = 20;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [9:0] pins = '0;
  logic [11:0][2:0] dsel = '0;
  logic [12:0][15:0] dval = '0;
  cst_sel_t sys_sel = 3'h0, imo_sel = 3'h2;
  logic [1:0] pref = 2'h0, dbl = 2'h0;
  logic [7:0] fb = 8'h08;
  logic [47:0] trim = 48'h6655_4433_2211;
  logic pll_en = 0, usb = 0, hib = 0, dbg = 0, clr = 0, wen = 0, ien = 0, fen = 1;
  logic [3:0] wsel = 4'h0;
  logic [4:0] term = 5'h03;
  logic [12:0] dclk, spc;
  logic cpu, prc, pok, plk, pev, drc, third, swk, sirq, firq, osec;
  cst_sel_t rng;
  cst_trim_t itrim;
  logic [4:0] fpc;
  logic [6:0] ev_d = '0;
  wire logic [6:0] ev = {pev, sirq, swk, firq, third, cpu, dclk[0]};
  int n_errors = 0, n_checks = 0;
  int cnt[7], base[7];

  cst_clock_sources #(.PLL_LOCK_CYCLES(LOCK)) dut_u (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .internal_main_osc_i(pins[0]),
    .fast_crystal_osc_i(pins[1]), .routed_clk_i(pins[2]), .pll_clk_i(pins[3]),
    .doubler_clk_i(pins[4]), .fast_low_power_clock_i(pins[5]), .slow_tick_clock_i(pins[6]),
    .watch_crystal_osc_i(pins[7]), .routed_div_clk_i({7'h0, pins[8]}), .usb_sof_i(pins[9]),
    .div_sel_i(dsel), .div_val_i(dval), .sys_src_sel_i(sys_sel), .div_clk_o(dclk),
    .cpu_clk_o(cpu), .pll_enable_i(pll_en), .pll_ref_sel_i(pref), .pll_in_div_i(4'h1),
    .pll_fb_div_i(fb), .pll_ref_clk_o(prc), .pll_ratio_ok_o(pok), .pll_locked_o(plk),
    .pll_lock_event_o(pev), .doubler_sel_i(dbl), .doubler_ref_clk_o(drc),
    .imo_range_sel_i(imo_sel), .imo_factory_trim_i(trim), .imo_usb_lock_i(usb),
    .imo_range_o(rng), .imo_trim_o(itrim), .divided_third_clock_o(third),
    .hibernate_i(hib), .debug_halt_i(dbg), .spc_clear_i(clr), .spc_wake_en_i(wen),
    .spc_irq_en_i(ien), .spc_wake_sel_i(wsel), .slow_periodic_counter_o(spc),
    .spc_wake_o(swk), .spc_irq_o(sirq), .fpc_terminal_i(term), .fpc_irq_en_i(fen),
    .fast_periodic_counter_o(fpc), .fpc_irq_o(firq), .one_second_o(osec));

  always #20 core_clk_i = ~core_clk_i;
  // count rising edges of watched outputs
  always @(posedge core_clk_i) begin
    ev_d <= ev;
    for (int i = 0; i < 7; i++) if (ev[i] && !ev_d[i]) cnt[i]++;
  end

  task wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : wt
  // slow square pulses on the masked pins, 4 cycles high and 4 low
  task pulse(input logic [9:0] m, input int n);
    repeat (n) begin
      pins <= pins | m;
      wt(4);
      pins <= pins & ~m;
      wt(4);
    end
    wt(4);
  endtask : pulse
  function automatic int d(input int i);
    return cnt[i] - base[i];
  endfunction : d

  task t_imo;
    `CHK("range_rst", 3'h2, rng)
    for (int k = 0; k < 6; k++) begin
      imo_sel <= 3'(k);
      wt(4);
      `CHK("range", 3'(k), rng)
      `CHK("trim", 8'(8'h11 * (k + 1)), itrim)
    end
    imo_sel <= 3'h6;
    usb <= 1'b1;
    pulse(10'h201, 2);
    `CHK("range_keep", 3'h5, rng)
    `CHK("usb_trim", 8'h68, itrim)
    usb <= 1'b0;
    wt(4);
    `CHK("usb_off", 8'h66, itrim)
  endtask : t_imo

  task t_refs;
    for (int s = 0; s < 3; s++) begin
      pins[2:0] <= 3'b001 << s;
      pref <= 2'(s);
      dbl <= 2'((s + 1) % 3);
      wt(6);
      `CHK("pll_ref", 1'b1, prc)
      `CHK("dbl_ref", 1'b0, drc)
    end
    pins[2:0] <= 3'h0;
  endtask : t_refs

  task t_pll;
    int i;
    base = cnt;
    pll_en <= 1'b1;
    for (i = 0; i < 200 && plk !== 1'b1; i++) wt(1);
    if (i == 200) begin
      n_errors++;
      finish_test();
    end
    `CHK("lock_time", 1'b1, i >= LOCK && i <= LOCK + 4)
    wt(2);
    `CHK("lock_evt", 1, d(6))
    fb <= 8'h03;
    wt(60);
    `CHK("bad_ratio_ok", 1'b0, pok)
    `CHK("bad_ratio_lock", 1'b0, plk)
    // pll off before any later hibernate stimulus
    pll_en <= 1'b0;
    wt(4);
    `CHK("pll_off_lock", 1'b0, plk)
  endtask : t_pll

  task t_div;
    dsel[0] <= 3'h7;
    dval[0] <= 16'h0004;
    dval[12] <= 16'h0006;
    sys_sel <= 3'h3;
    pref <= 2'h0;
    pulse(10'h101, 12);
    base = cnt;
    pulse(10'h101, 24);
    `CHK("div0_rises", 6, d(0))
    `CHK("bus_rises", 4, d(1))
    dval[0] <= 16'h0002;
    pulse(10'h101, 8);
    base = cnt;
    pulse(10'h101, 8);
    `CHK("div0_new", 4, d(0))
  endtask : t_div

  task t_fast;
    base = cnt;
    pulse(10'h020, 9);
    `CHK("fpc_val", 5'h01, fpc)
    `CHK("fpc_irq", 2, d(3))
    `CHK("third", 3, d(2))
    fen <= 1'b0;
    base = cnt;
    pulse(10'h020, 4);
    `CHK("fpc_irq_off", 0, d(3))
  endtask : t_fast

  task t_slow;
    wen <= 1'b1;
    ien <= 1'b1;
    base = cnt;
    pulse(10'h040, 8);
    `CHK("spc_run", 13'h0008, spc)
    `CHK("wake", 4, d(4))
    `CHK("wake_irq", 4, d(5))
    hib <= 1'b1;
    pulse(10'h040, 3);
    hib <= 1'b0;
    dbg <= 1'b1;
    pulse(10'h040, 2);
    dbg <= 1'b0;
    `CHK("spc_stop", 13'h0008, spc)
    ien <= 1'b0;
    base = cnt;
    pulse(10'h040, 4);
    `CHK("spc_more", 13'h000C, spc)
    `CHK("wake2", 2, d(4))
    `CHK("no_irq", 0, d(5))
    clr <= 1'b1;
    wt(2);
    clr <= 1'b0;
    wt(1);
    `CHK("spc_clr", 13'h0000, spc)
  endtask : t_slow

  task finish_test;
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    for (int k = 0; k < 13; k++) dval[k] = 16'h0002;
    wt(16);
    arst_n_i <= 1'b1;
    wt(3);
    t_imo();
    t_refs();
    t_pll();
    t_div();
    t_fast();
    t_slow();
    finish_test();
  end
endmodule : cst_clock_sources_bench
`default_nettype wire
